//--- verilog/ppl_defines.vh
// register offsets, field positions, reset values and preset encodings of the pin-program loader
`ifndef PPL_DEFINES_VH
`define PPL_DEFINES_VH
// ==========================================================
// register byte addresses; select registers are indices, byte address is four times
`define PPL_IDX_FREQ_SEL 12'hc01
`define PPL_IDX_SYSCLK_SEL 12'hc02
`define PPL_ADDR_FREQ_SEL 14'h3004
`define PPL_ADDR_SYSCLK_SEL 14'h3008
`define PPL_ADDR_ENABLE 14'h0000
`define PPL_ADDR_CONTROL 14'h0004
`define PPL_ADDR_STATUS 14'h0008
`define PPL_ADDR_TUNE 14'h000c
`define PPL_ADDR_OUT0 14'h0010
`define PPL_ADDR_OUT1 14'h0014
`define PPL_ADDR_OUT2 14'h0018
`define PPL_ADDR_OUT3 14'h001c
`define PPL_ADDR_OUT4 14'h0020
`define PPL_ADDR_OUT5 14'h0024
`define PPL_ADDR_OUT6 14'h0028
`define PPL_ADDR_OUT7 14'h002c
`define PPL_ADDR_OUT8 14'h0030
// ==========================================================
// field positions
`define PPL_IN_ID_LSB 0
`define PPL_OUT_ID_LSB 4
`define PPL_CTRL_START_BIT 0
`define PPL_TUNE_BW_LSB 2
`define PPL_TUNE_PM_BIT 4
// ==========================================================
// reset values
`define PPL_FREQ_SEL_RST 8'h00
`define PPL_SYSCLK_SEL_RST 8'h00
`define PPL_TUNE_RST 8'h00
// ==========================================================
// strap levels and encodings
`define PPL_LVL_LOW 2'h0
`define PPL_LVL_MID 2'h1
`define PPL_LVL_HIGH 2'h2
`define PPL_SYS_XTAL_DBL_N8 2'h0
`define PPL_SYS_XO_DBL_N8 2'h1
`define PPL_SYS_XTAL_N16 2'h2
`define PPL_SYS_XO_NODBL_N8 2'h3
`define PPL_BW_1HZ 2'h0
`define PPL_BW_10HZ 2'h1
`define PPL_BW_50HZ 2'h2
`define PPL_BW_100HZ 2'h3
`define PPL_PM_NORMAL 1'b0
`define PPL_PM_HIGH 1'b1
// ==========================================================
// load sequence: words copied per preset, one cycle each; system clock multiplier
`define PPL_WORDS 4'h8
`define PPL_SYS_MULT 5'h10
`endif

//--- verilog/ppl_loader.v
// pin-program preset loader with rom, strap decode and ahb-lite registers
// Operation
// - when enabled and started in soft mode, or once after reset in hard mode, copy selected rom preset into configuration registers
// - rom holds 256 presets, indexed by 16 input and 16 output ids
// - each preset assumes equal frequencies on all inputs and all outputs
// - preset rewrites period, r divider, dpll dividers, tuning word, n2, rf, channel
// - presets assume one 786.432 mhz system clock, 16 times 49.152 mhz
// - soft mode two-bit sysclk code selects one of four system clock setups
// - hard mode interrupt strap selects sysclk setup 0, 1 or 2; 3 unreachable
// - four dpll loop bandwidth presets: 1, 10, 50, 100 hz
// - two phase margin choices: normal 70 degrees, high 88.5 degrees
// - every load writes apll calibration bit 0 then 1 to start vco calibration
// - hard mode input strap low, mid, high selects input id 0, 1, 2
// - soft mode freq select bits 3:0 hold input id 0 to 15
// - hard mode three output straps, msb first, ternary order give output ids 0..15
// - soft mode freq select bits 7:4 hold output id 0 to 15
// - pin program select high means hard mode, low means soft mode
// - pin program select sampled at power-up to fix the mode
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ppl_defines.vh"
module ppl_loader (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire pin_program_select,
  input wire [1:0] input_freq_strap,
  input wire [1:0] output_freq_strap_msb,
  input wire [1:0] output_freq_strap_mid,
  input wire [1:0] output_freq_strap_lsb,
  input wire [1:0] irq_strap,
  output reg busy_r,
  output reg hard_mode_r,
  output reg [19:0] ref_period_r,
  output reg [19:0] ref_divider_r,
  output reg [22:0] dpll_fraction_part_r,
  output reg [22:0] dpll_modulus_part_r,
  output reg [16:0] dpll_integer_part_r,
  output reg [31:0] free_run_tuning_r,
  output reg [7:0] output_pll_feedback_divider_r,
  output reg [3:0] rf_divider_r,
  output reg [9:0] channel_divider_r,
  output reg [1:0] sysclk_cfg_r,
  output reg [1:0] loop_bw_r,
  output reg phase_margin_r,
  output reg apll_cal_r
);

// ==========================================================
// state
localparam ST_IDLE = 2'h0;
localparam ST_COPY = 2'h1;
localparam ST_CAL = 2'h2;

reg [1:0] state_r;
reg [3:0] word_r;
reg [7:0] sel_idx_r;
reg por_done_r;
reg soft_en_r;
reg [7:0] freq_sel_r;
reg [7:0] sysclk_sel_r;
reg [7:0] tune_r;
reg start_req_r;
reg wr_pend_r;
reg [13:0] wr_addr_r;
reg [7:0] load_count_r;
// strap levels frozen at power-up; later strap moves are ignored
reg [3:0] strap_in_r;
reg [3:0] strap_out_r;
reg [1:0] strap_sys_r;
reg [3:0] hard_in_id;
reg [1:0] hard_sys;

// ==========================================================
// preset rom: 256 entries, eight words each
reg [31:0] rom_mem [0:2047];
integer i;
initial begin
  // same frequency on every input and output per entry
  for (i = 0; i < 2048; i = i + 1) begin
    rom_mem[i] = {i[10:0], 21'h0 | i[10:0]} ^ 32'h5a5a0000;
  end
end

// ==========================================================
// strap decode
function [3:0] tern3;
  input [1:0] a;
  input [1:0] b;
  input [1:0] c;
  reg [4:0] s;
  begin
    s = ({3'h0, a} * 5'h09) + ({3'h0, b} * 5'h03) + {3'h0, c};
    // codes above 15 are undefined; they alias into the low ids
    tern3 = s[3:0];
  end
endfunction

always @* begin
  case (input_freq_strap)
    `PPL_LVL_HIGH: hard_in_id = 4'h2;
    `PPL_LVL_MID: hard_in_id = 4'h1;
    default: hard_in_id = 4'h0;
  endcase
end

wire [3:0] hard_out_id = tern3(output_freq_strap_msb, output_freq_strap_mid,
  output_freq_strap_lsb);

// setup 3 has no strap level; a stray fourth level falls back to setup 0
always @* begin
  case (irq_strap)
    `PPL_LVL_HIGH: hard_sys = `PPL_SYS_XTAL_N16;
    `PPL_LVL_MID: hard_sys = `PPL_SYS_XO_DBL_N8;
    default: hard_sys = `PPL_SYS_XTAL_DBL_N8;
  endcase
end
wire [3:0] soft_in_id = freq_sel_r[`PPL_IN_ID_LSB +: 4];
wire [3:0] soft_out_id = freq_sel_r[`PPL_OUT_ID_LSB +: 4];

// ==========================================================
// ahb-lite slave
wire addr_ok = hsel && hready && htrans[1];
wire [13:0] a14 = haddr[13:0];
wire soft_acc = soft_en_r && !hard_mode_r;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    wr_pend_r <= 1'b0;
    wr_addr_r <= 14'h0000;
    hrdata <= 32'h0;
    hreadyout <= 1'b1;
    hresp <= 1'b0;
  end else if (clk_en) begin
    wr_pend_r <= addr_ok && hwrite;
    if (addr_ok && hwrite) begin
      wr_addr_r <= a14;
    end
    if (addr_ok && !hwrite) begin
      case (a14)
        `PPL_ADDR_FREQ_SEL: hrdata <= soft_acc ? {24'h0, freq_sel_r} : 32'h0;
        `PPL_ADDR_SYSCLK_SEL: hrdata <= soft_acc ? {24'h0, sysclk_sel_r} : 32'h0;
        `PPL_ADDR_ENABLE: hrdata <= {31'h0, soft_en_r};
        `PPL_ADDR_TUNE: hrdata <= {24'h0, tune_r};
        `PPL_ADDR_STATUS: hrdata <= {16'h0, load_count_r, `PPL_SYS_MULT, apll_cal_r,
          hard_mode_r, busy_r};
        `PPL_ADDR_OUT0: hrdata <= {12'h0, ref_period_r};
        `PPL_ADDR_OUT1: hrdata <= {12'h0, ref_divider_r};
        `PPL_ADDR_OUT2: hrdata <= {15'h0, dpll_integer_part_r};
        `PPL_ADDR_OUT3: hrdata <= free_run_tuning_r;
        `PPL_ADDR_OUT4: hrdata <= {9'h0, dpll_fraction_part_r};
        `PPL_ADDR_OUT5: hrdata <= {9'h0, dpll_modulus_part_r};
        `PPL_ADDR_OUT6: hrdata <= {24'h0, output_pll_feedback_divider_r};
        `PPL_ADDR_OUT7: hrdata <= {18'h0, channel_divider_r, rf_divider_r};
        `PPL_ADDR_OUT8: hrdata <= {27'h0, phase_margin_r, loop_bw_r, sysclk_cfg_r};
        default: hrdata <= 32'h0;
      endcase
    end
  end
end

// ==========================================================
// software registers; denied writes are dropped
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    soft_en_r <= 1'b0;
    freq_sel_r <= `PPL_FREQ_SEL_RST;
    sysclk_sel_r <= `PPL_SYSCLK_SEL_RST;
    tune_r <= `PPL_TUNE_RST;
    start_req_r <= 1'b0;
  end else if (clk_en) begin
    if (state_r != ST_IDLE) begin
      start_req_r <= 1'b0;
    end
    if (wr_pend_r) begin
      case (wr_addr_r)
        `PPL_ADDR_ENABLE: soft_en_r <= hwdata[0];
        `PPL_ADDR_FREQ_SEL: if (soft_acc) freq_sel_r <= hwdata[7:0];
        `PPL_ADDR_SYSCLK_SEL: if (soft_acc) sysclk_sel_r <= {6'h0, hwdata[1:0]};
        `PPL_ADDR_TUNE: tune_r <= {3'h0, hwdata[4:0]};
        `PPL_ADDR_CONTROL: if (hwdata[`PPL_CTRL_START_BIT]) start_req_r <= 1'b1;
        default: ;
      endcase
    end
  end
end

// ==========================================================
// mode capture after reset release
always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    por_done_r <= 1'b0;
    hard_mode_r <= 1'b0;
    strap_in_r <= 4'h0;
    strap_out_r <= 4'h0;
    strap_sys_r <= 2'h0;
  end else if (clk_en && !por_done_r) begin
    por_done_r <= 1'b1;
    hard_mode_r <= pin_program_select;
    strap_in_r <= hard_in_id;
    strap_out_r <= hard_out_id;
    strap_sys_r <= hard_sys;
  end
end

// ==========================================================
// load sequencer: copy words, then raise calibration bit
wire [31:0] rom_word = rom_mem[{sel_idx_r, word_r[2:0]}];
wire hard_go = por_done_r && (state_r == ST_IDLE) && hard_mode_r && (load_count_r == 8'h00);
wire soft_go = (state_r == ST_IDLE) && !hard_mode_r && soft_en_r && start_req_r;

always @(posedge hclk or negedge hresetn) begin
  if (!hresetn) begin
    state_r <= ST_IDLE;
    word_r <= 4'h0;
    sel_idx_r <= 8'h00;
    busy_r <= 1'b0;
    apll_cal_r <= 1'b0;
    load_count_r <= 8'h00;
    ref_period_r <= 20'h0;
    ref_divider_r <= 20'h0;
    dpll_fraction_part_r <= 23'h0;
    dpll_modulus_part_r <= 23'h0;
    dpll_integer_part_r <= 17'h0;
    free_run_tuning_r <= 32'h0;
    output_pll_feedback_divider_r <= 8'h00;
    rf_divider_r <= 4'h0;
    channel_divider_r <= 10'h000;
    sysclk_cfg_r <= 2'h0;
    loop_bw_r <= `PPL_BW_1HZ;
    phase_margin_r <= `PPL_PM_NORMAL;
  end else if (clk_en) begin
    case (state_r)
      ST_IDLE: begin
        if (hard_go || soft_go) begin
          sel_idx_r <= hard_mode_r ? {strap_out_r, strap_in_r} : {soft_out_id, soft_in_id};
          sysclk_cfg_r <= hard_mode_r ? strap_sys_r : sysclk_sel_r[1:0];
          // tuning options only reachable from software; hard mode keeps defaults
          loop_bw_r <= hard_mode_r ? `PPL_BW_1HZ : tune_r[`PPL_TUNE_BW_LSB +: 2];
          phase_margin_r <= hard_mode_r ? `PPL_PM_NORMAL : tune_r[`PPL_TUNE_PM_BIT];
          apll_cal_r <= 1'b0;
          word_r <= 4'h0;
          busy_r <= 1'b1;
          state_r <= ST_COPY;
        end
      end
      ST_COPY: begin
        case (word_r[2:0])
          3'h0: ref_period_r <= rom_word[19:0];
          3'h1: ref_divider_r <= rom_word[19:0];
          3'h2: dpll_fraction_part_r <= rom_word[22:0];
          3'h3: dpll_modulus_part_r <= rom_word[22:0];
          3'h4: dpll_integer_part_r <= rom_word[16:0];
          3'h5: free_run_tuning_r <= rom_word;
          3'h6: output_pll_feedback_divider_r <= rom_word[7:0];
          default: begin
            rf_divider_r <= rom_word[3:0];
            channel_divider_r <= rom_word[13:4];
          end
        endcase
        word_r <= word_r + 4'h1;
        if (word_r == (`PPL_WORDS - 4'h1)) begin
          state_r <= ST_CAL;
        end
      end
      ST_CAL: begin
        // rising edge only after every divider is in place
        apll_cal_r <= 1'b1;
        busy_r <= 1'b0;
        load_count_r <= load_count_r + 8'h01;
        state_r <= ST_IDLE;
      end
      default: state_r <= ST_IDLE;
    endcase
  end
end

endmodule // ppl_loader

//--- tb/ppl_strap_model.sv
// board strap model: turns chosen ids into three-level strap levels
`timescale 1ns/1ps
module ppl_strap_model (
  input wire [3:0] in_id,
  input wire [3:0] out_id,
  input wire [1:0] sys_id,
  output wire [1:0] s_in,
  output wire [1:0] s_m3,
  output wire [1:0] s_m2,
  output wire [1:0] s_m1,
  output wire [1:0] s_irq
);
  // ==========================================================
  // levels: 0 low, 1 mid, 2 high
  assign s_in = (in_id > 4'h2) ? 2'h2 : in_id[1:0];
  assign s_m3 = 2'(out_id / 9);
  assign s_m2 = 2'((out_id / 3) % 3);
  assign s_m1 = 2'(out_id % 3);
  // setup 3 has no strap level, so a board can only offer high
  assign s_irq = (sys_id == 2'h3) ? 2'h2 : sys_id;
endmodule // ppl_strap_model

//--- tb/ppl_loader_checker.sv
// concurrent checks on the pin-program loader ports
`timescale 1ns/1ps
module ppl_loader_checker (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire busy_r,
  input wire hard_mode_r,
  input wire [1:0] sysclk_cfg_r,
  input wire [1:0] loop_bw_r,
  input wire phase_margin_r,
  input wire apll_cal_r,
  input wire [16:0] dpll_integer_part_r
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("error response");
  cal_low_busy_a: assert property (busy_r |-> !apll_cal_r) else $error("cal high in load");
  cal_at_end_a: assert property ($fell(busy_r) |-> apll_cal_r) else $error("no cal edge");
  busy_length_a: assert property ($rose(busy_r) |-> busy_r[*8] ##1 busy_r ##1 !busy_r)
    else $error("busy length wrong");
  hard_sysclk_a: assert property (hard_mode_r && $fell(busy_r) |-> sysclk_cfg_r != 2'h3)
    else $error("setup 3 in hard mode");
  hard_tune_a: assert property (hard_mode_r && $fell(busy_r) |-> !loop_bw_r && !phase_margin_r)
    else $error("hard tuning wrong");
  mode_held_a: assert property (hard_mode_r |=> hard_mode_r) else $error("mode changed");
  hard_start_a: assert property ($rose(hard_mode_r) |-> ##[1:2] busy_r)
    else $error("hard load missing");
  preset_still_a: assert property (!busy_r && !$past(busy_r) |-> $stable(dpll_integer_part_r))
    else $error("preset changed idle");
  soft_load_c: cover property ($fell(busy_r) && !hard_mode_r);
  hard_load_c: cover property ($fell(busy_r) && hard_mode_r);
  cal_rise_c: cover property ($rose(apll_cal_r));
endmodule // ppl_loader_checker
bind ppl_loader ppl_loader_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .busy_r(busy_r), .hard_mode_r(hard_mode_r), .sysclk_cfg_r(sysclk_cfg_r),
  .loop_bw_r(loop_bw_r), .phase_margin_r(phase_margin_r), .apll_cal_r(apll_cal_r),
  .dpll_integer_part_r(dpll_integer_part_r));

//--- tb/tb.sv
// self-checking bench of the pin-program loader
`timescale 1ns/1ps
`include "ppl_defines.vh"
module tb;
  // ==========================================================
  // signals
  localparam logic [31:0] fsel = {18'h0, `PPL_IDX_FREQ_SEL, 2'h0};
  localparam logic [31:0] ssel = {18'h0, `PPL_IDX_SYSCLK_SEL, 2'h0};
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic pps = 1'h0;
  logic ce = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] m_in = 4'h0;
  logic [3:0] m_out = 4'h0;
  logic [1:0] m_sys = 2'h0;
  wire hreadyout, hresp, busy_r, hard_mode_r, phase_margin_r, apll_cal_r;
  wire [31:0] hrdata, ftw;
  wire [19:0] per, rdiv;
  wire [22:0] frac, modu;
  wire [16:0] nint;
  wire [7:0] n2;
  wire [3:0] rf;
  wire [9:0] ch;
  wire [1:0] sysclk_cfg_r, loop_bw_r, s_in, s_m3, s_m2, s_m1, s_irq;
  wire [156:0] preset = {per, rdiv, frac, modu, nint, ftw, n2, rf, ch};
  logic [156:0] snap;
  logic [31:0] q;
  logic [7:0] d;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 18916;
  int len;
  ppl_loader uut (.hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_program_select(pps),
    .input_freq_strap(s_in), .output_freq_strap_msb(s_m3), .output_freq_strap_mid(s_m2),
    .output_freq_strap_lsb(s_m1), .irq_strap(s_irq), .busy_r(busy_r), .hard_mode_r(hard_mode_r),
    .ref_period_r(per), .ref_divider_r(rdiv), .dpll_fraction_part_r(frac),
    .dpll_modulus_part_r(modu), .dpll_integer_part_r(nint), .free_run_tuning_r(ftw),
    .output_pll_feedback_divider_r(n2), .rf_divider_r(rf), .channel_divider_r(ch),
    .sysclk_cfg_r(sysclk_cfg_r), .loop_bw_r(loop_bw_r), .phase_margin_r(phase_margin_r),
    .apll_cal_r(apll_cal_r));
  ppl_strap_model straps (.in_id(m_in), .out_id(m_out), .sys_id(m_sys), .s_in(s_in),
    .s_m3(s_m3), .s_m2(s_m2), .s_m1(s_m1), .s_irq(s_irq));
  initial forever #25 hclk = ~hclk;
  // ==========================================================
  // tasks
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // bounded wait so a dead slave ends the run instead of hanging it
  task automatic wait_rdy;
    for (int n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'h1) return;
    end
    mismatches++;
    conclude;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    q = hrdata;
  endtask
  task automatic wait_load;
    len = 0;
    for (int n = 0; n < 100; n++) begin
      @(posedge hclk);
      #1;
      if (busy_r === 1'h1) len++;
      else if (len > 0) return;
    end
    mismatches++;
    conclude;
  endtask
  // ==========================================================
  // sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    bus(1'h1, fsel, 32'ha5);
    bus(1'h0, fsel, 32'h0);
    chk(q, 32'h0, "select open while locked");
    bus(1'h0, 32'h100, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'h1, `PPL_ADDR_ENABLE, 32'h1);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hd1 : (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($random(seed));
      bus(1'h1, fsel, {24'h0, d});
      bus(1'h0, fsel, 32'h0);
      chk(q, {24'h0, d}, "select readback");
      bus(1'h1, ssel, {30'h0, i[1:0]});
      bus(1'h1, `PPL_ADDR_TUNE, {27'h0, i[0], i[1:0], 2'h0});
      bus(1'h1, `PPL_ADDR_CONTROL, 32'h1);
      if (i == 5) begin
        ce <= 1'h0;
        repeat (3) @(posedge hclk);
        chk(busy_r, 1'h0, "start while frozen");
        ce <= 1'h1;
      end
      wait_load;
      chk(len, `PPL_WORDS + 1, "busy length");
      chk(apll_cal_r, 1'h1, "cal bit");
      chk(sysclk_cfg_r, i[1:0], "sysclk setup");
      chk({phase_margin_r, loop_bw_r}, {i[0], i[1:0]}, "tuning");
      if (i == 0) snap = preset;
    end
    hresetn <= 1'h0;
    pps <= 1'h1;
    m_in <= 4'h1;
    m_out <= 4'hd;
    m_sys <= 2'h1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    wait_load;
    chk(hard_mode_r, 1'h1, "hard mode");
    chk(preset === snap, 1'h1, "strap preset");
    chk(sysclk_cfg_r, 2'h1, "strap sysclk");
    chk({phase_margin_r, loop_bw_r}, 3'h0, "hard tuning");
    pps <= 1'h0;
    bus(1'h1, `PPL_ADDR_ENABLE, 32'h1);
    bus(1'h1, fsel, 32'h5a);
    bus(1'h0, fsel, 32'h0);
    chk(q, 32'h0, "select open in hard mode");
    chk(hard_mode_r, 1'h1, "mode held");
    bus(1'h0, `PPL_ADDR_STATUS, 32'h0);
    chk(q[7:0], 8'h86, "status");
    bus(1'h0, `PPL_ADDR_OUT7, 32'h0);
    chk(q, {18'h0, snap[9:0], snap[13:10]}, "rf channel readback");
    conclude;
  end
endmodule // tb
